// file: vte_cmp.sv
`timescale 1ns/10ps
// one strict comparator pair per slot; the top picks under or over per element
module vte_cmp (
  vte_cmp_if.cmp c
);
  import vte_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NCMP; i++) begin : g_cmp
      assign c.below[i] = c.mag[i] < c.pick[i];   // see RL1
      assign c.above[i] = c.mag[i] > c.pick[i];   // see RL2
    end
  endgenerate

endmodule : vte_cmp

// file: vte_cmp_if.sv
`timescale 1ns/10ps
interface vte_cmp_if;
  import vte_pkg::*;
  logic [MAG_W-1:0] mag   [NCMP];
  logic [MAG_W-1:0] pick  [NCMP];
  logic [NCMP-1:0]  below;
  logic [NCMP-1:0]  above;
  modport cmp  (input mag, input pick, output below, output above);
  modport user (output mag, output pick, input below, input above);
endinterface : vte_cmp_if

// file: vte_consumer.sv
`timescale 1ns/10ps
// ****
// far-side consumer of element bits
// ****
module vte_consumer (
  input  wire logic                     mclk,
  input  wire logic [vte_pkg::NCMP-1:0] elem_q,
  input  wire logic [3:0]               weak_infeed_q,
  output logic      [3:0]               wi_seen_q,
  output logic      [2:0]               uv_seen_q
);
  import vte_pkg::*;
  // with a wye connection the weak-infeed path and a general user both read the same phase bits
  always_ff @(posedge mclk) begin
    wi_seen_q <= weak_infeed_q;
    uv_seen_q <= elem_q[C_UV1+2:C_UV1];
  end
endmodule : vte_consumer

// file: vte_pkg.sv
// Behaviour
// RL1 - every undervoltage element is set while its operating magnitude is below its pickup and clear otherwise.
// RL2 - every overvoltage element is set while its operating magnitude is above its pickup and clear otherwise.
// RL3 - the level-one phase A, B and C undervoltage bits are set when the phase magnitude is strictly below the shared level-one undervoltage pickup.
// RL4 - the three-phase undervoltage bit is set only when all three per-phase undervoltage bits are set.
// RL5 - the level-one phase A, B and C overvoltage bits are set when the phase magnitude is strictly above the shared level-one overvoltage pickup.
// RL6 - the three-phase overvoltage bit is set only when all three per-phase overvoltage bits are set.
// RL7 - with a delta connection the phase-to-phase under- and overvoltage pickups accept 0.00 to 300.00 V on 300 V inputs.
// RL8 - with a delta connection both negative-sequence overvoltage pickups span 0.00 to 60.00 V on 150 V inputs and 0.00 to 120.00 V on 300 V inputs.
// RL9 - with a delta connection the positive-sequence overvoltage pickup spans 0.00 to 85.00 V on 150 V inputs and 0.00 to 170.00 V on 300 V inputs.
// RL10 - with a wye connection the level-one phase undervoltage bits and the first zero-sequence overvoltage bit feed the weak-infeed logic while it is enabled.
// RL11 - with a delta connection the phase-to-phase undervoltage bits and the negative-sequence overvoltage bit feed the weak-infeed logic while it is enabled.
// RL12 - bits that feed the weak-infeed logic stay available to every other consumer whatever the weak-infeed enable is.
// RL13 - a connection setting picks wye or delta and so which elements and operating quantities are active.
// RL14 - software keeps voltage pickups at or above 2.00 V so that elements do not chatter on noise.
// RL15 - all comparisons are taken from the latest magnitudes once per processing interval and all bits update together.
package vte_pkg;

  localparam int MAG_W  = 16;   // magnitudes and pickups in units of 10 mV
  localparam int NCMP   = 22;
  localparam int NPICK  = 10;
  localparam int ADDR_W = 8;

  // comparator slots
  localparam int C_UV1   = 0;
  localparam int C_OV1   = 3;
  localparam int C_UVPP  = 6;
  localparam int C_UVPP2 = 9;
  localparam int C_OVPP  = 12;
  localparam int C_OVPP2 = 15;
  localparam int C_ZS    = 18;
  localparam int C_NQ    = 19;
  localparam int C_NQ2   = 20;
  localparam int C_PS    = 21;

  // pickup register slots
  localparam int P_UV1   = 0;
  localparam int P_OV1   = 1;
  localparam int P_UVPP  = 2;
  localparam int P_UVPP2 = 3;
  localparam int P_OVPP  = 4;
  localparam int P_OVPP2 = 5;
  localparam int P_ZS    = 6;
  localparam int P_NQ    = 7;
  localparam int P_NQ2   = 8;
  localparam int P_PS    = 9;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ELEM  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PICK0 = 8'h10;

  localparam int CTRL_DELTA_BIT = 0;
  localparam int CTRL_WI_BIT    = 1;
  localparam int CTRL_R300_BIT  = 2;
  localparam logic [2:0]       CTRL_RST  = 3'h0;
  localparam logic [MAG_W-1:0] PICK_RST  = 16'h0000;
  localparam logic [2:0]       IMASK_RST = 3'h0;

  localparam int IRQ_UV3_BIT = 0;
  localparam int IRQ_OV3_BIT = 1;
  localparam int IRQ_CHG_BIT = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // pickup ceilings in 10 mV steps
  localparam logic [MAG_W-1:0] LIM_150 = 16'd15000;
  localparam logic [MAG_W-1:0] LIM_300 = 16'd30000;
  localparam logic [MAG_W-1:0] LIM_260 = 16'd26000;
  localparam logic [MAG_W-1:0] LIM_520 = 16'd52000;
  localparam logic [MAG_W-1:0] LIM_60  = 16'd6000;
  localparam logic [MAG_W-1:0] LIM_120 = 16'd12000;
  localparam logic [MAG_W-1:0] LIM_85  = 16'd8500;
  localparam logic [MAG_W-1:0] LIM_170 = 16'd17000;
  localparam logic [MAG_W-1:0] LIM_100 = 16'd10000;
  localparam logic [MAG_W-1:0] LIM_200 = 16'd20000;

  localparam int CLK_PERIOD_NS     = 10;
  localparam int PROC_INTERVAL_NS  = 1000;
  localparam int PROC_INTERVAL_CYC = PROC_INTERVAL_NS / CLK_PERIOD_NS;

  // which comparator slots are elements of each connection
  localparam logic [NCMP-1:0] WYE_ACTIVE   = 22'h2C_71FF;
  localparam logic [NCMP-1:0] DELTA_ACTIVE = 22'h3B_FFC0;
  localparam logic [NCMP-1:0] UNDER_SLOTS  = 22'h00_0FC7;

  function automatic logic [MAG_W-1:0] pick_max(input int idx, input logic delta, input logic r300);
    logic [MAG_W-1:0] m;
    m = r300 ? LIM_300 : LIM_150;
    if ((idx == P_UVPP || idx == P_UVPP2 || idx == P_OVPP || idx == P_OVPP2) && !delta)
      m = r300 ? LIM_520 : LIM_260;
    else if (idx == P_NQ || idx == P_NQ2)
      m = delta ? (r300 ? LIM_120 : LIM_60) : (r300 ? LIM_200 : LIM_100);
    else if (idx == P_PS && delta)
      m = r300 ? LIM_170 : LIM_85;
    return m;
  endfunction : pick_max

endpackage : vte_pkg

// file: vte_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module vte_top (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_va,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_vb,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_vc,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_vab,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_vbc,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_vca,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_v0,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_v2,
  input  wire logic [vte_pkg::MAG_W-1:0] mag_v1,
  output logic      [vte_pkg::NCMP-1:0]  elem_q,
  output logic                           three_phase_under_q,
  output logic                           three_phase_over_q,
  output logic      [3:0]                weak_infeed_q,
  output logic                           irq_q,
  input  wire logic [vte_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic      [1:0]                s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [vte_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic      [31:0]               s_axi_rdata,
  output logic      [1:0]                s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import vte_pkg::*;

  // ****************************************
  // settings and state
  // ****************************************
  logic [2:0]       ctrl_q;
  logic [MAG_W-1:0] pick_q [NPICK];
  logic [2:0]       istat_q;
  logic [2:0]       imask_q;
  logic [15:0]      tick_cnt_q;
  logic             tick_q;

  wire delta  = ctrl_q[CTRL_DELTA_BIT];
  wire wi_en  = ctrl_q[CTRL_WI_BIT];
  wire r300   = ctrl_q[CTRL_R300_BIT];

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : strb_merge

  // ****************************************
  // axi4-lite write path
  // ****************************************
  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_have_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              w_have_q;

  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire do_wr     = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire aw_have_n = (aw_have_q | aw_take) & ~do_wr;
  wire w_have_n  = (w_have_q | w_take) & ~do_wr;
  wire bvalid_n  = (s_axi_bvalid & ~s_axi_bready) | do_wr;

  wire [ADDR_W-1:0] pick_off = aw_addr_q - OFF_PICK0;
  wire [ADDR_W-3:0] pick_idx = pick_off[ADDR_W-1:2];
  wire              wr_ctrl  = do_wr && aw_addr_q == OFF_CTRL;
  wire              wr_istat = do_wr && aw_addr_q == OFF_ISTAT;
  wire              wr_imask = do_wr && aw_addr_q == OFF_IMASK;
  wire              wr_pick  = do_wr && aw_addr_q >= OFF_PICK0 && aw_addr_q[1:0] == 2'h0
                               && pick_idx < 6'(NPICK);
  wire              wr_map   = wr_ctrl | wr_istat | wr_imask | wr_pick | (aw_addr_q == OFF_ELEM);
  wire [31:0]       w1c_bits = strb_merge(32'h0000_0000, w_data_q, w_strb_q);
  wire [31:0]       ctrl_mrg  = strb_merge({29'h0, ctrl_q}, w_data_q, w_strb_q);
  wire [31:0]       imask_mrg = strb_merge({29'h0, imask_q}, w_data_q, w_strb_q);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_have_q     <= aw_have_n;
      w_have_q      <= w_have_n;
      s_axi_awready <= ~aw_have_n & ~bvalid_n;
      s_axi_wready  <= ~w_have_n & ~bvalid_n;
      s_axi_bvalid  <= bvalid_n;
      if (do_wr) s_axi_bresp <= wr_map ? RESP_OKAY : RESP_DECERR;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q  <= CTRL_RST;
      imask_q <= IMASK_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_mrg[2:0];   // see RL13
      if (wr_imask) imask_q <= imask_mrg[2:0];
    end
  end

  // pickups are clamped to the ceiling of the current connection and rating when written
  genvar k;
  generate
    for (k = 0; k < NPICK; k++) begin : g_pick
      wire [31:0]      merged = strb_merge({16'h0000, pick_q[k]}, w_data_q, w_strb_q);
      wire [MAG_W-1:0] ceil_v = pick_max(k, delta, r300);
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) pick_q[k] <= PICK_RST;
        else if (wr_pick && pick_idx == 6'(k))
          pick_q[k] <= (merged[MAG_W-1:0] > ceil_v) ? ceil_v : merged[MAG_W-1:0];   // see RL7 see RL8 see RL9
      end
    end
  endgenerate

  // ****************************************
  // axi4-lite read path
  // ****************************************
  wire              ar_take   = s_axi_arvalid & s_axi_arready;
  wire [ADDR_W-1:0] rpick_off = s_axi_araddr - OFF_PICK0;
  wire [ADDR_W-3:0] rpick_idx = rpick_off[ADDR_W-1:2];
  logic [31:0]      rd_val;
  logic             rd_hit;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFF_CTRL) rd_val = {29'h0, ctrl_q};
    else if (s_axi_araddr == OFF_ELEM) rd_val = {10'h0, elem_q};
    else if (s_axi_araddr == OFF_ISTAT) rd_val = {29'h0, istat_q};
    else if (s_axi_araddr == OFF_IMASK) rd_val = {29'h0, imask_q};
    else if (s_axi_araddr >= OFF_PICK0 && s_axi_araddr[1:0] == 2'h0 && rpick_idx < 6'(NPICK))
      rd_val = {16'h0000, pick_q[rpick_idx[3:0]]};
    else rd_hit = 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // processing interval
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= tick_cnt_q == 16'(PROC_INTERVAL_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 16'(PROC_INTERVAL_CYC - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // element comparisons
  // ****************************************
  vte_cmp_if cif ();

  vte_cmp u_cmp (
    .c (cif)
  );

  wire [MAG_W-1:0] ph [3] = '{mag_va, mag_vb, mag_vc};
  wire [MAG_W-1:0] pp [3] = '{mag_vab, mag_vbc, mag_vca};

  genvar j;
  generate
    for (j = 0; j < 3; j++) begin : g_tri
      assign cif.mag[C_UV1+j]    = ph[j];
      assign cif.pick[C_UV1+j]   = pick_q[P_UV1];
      assign cif.mag[C_OV1+j]    = ph[j];
      assign cif.pick[C_OV1+j]   = pick_q[P_OV1];
      assign cif.mag[C_UVPP+j]   = pp[j];
      assign cif.pick[C_UVPP+j]  = pick_q[P_UVPP];
      assign cif.mag[C_UVPP2+j]  = pp[j];
      assign cif.pick[C_UVPP2+j] = pick_q[P_UVPP2];
      assign cif.mag[C_OVPP+j]   = pp[j];
      assign cif.pick[C_OVPP+j]  = pick_q[P_OVPP];
      assign cif.mag[C_OVPP2+j]  = pp[j];
      assign cif.pick[C_OVPP2+j] = pick_q[P_OVPP2];
    end
  endgenerate

  assign cif.mag[C_ZS]  = mag_v0;
  assign cif.pick[C_ZS] = pick_q[P_ZS];
  assign cif.mag[C_NQ]  = mag_v2;
  assign cif.pick[C_NQ] = pick_q[P_NQ];
  assign cif.mag[C_NQ2]  = mag_v2;
  assign cif.pick[C_NQ2] = pick_q[P_NQ2];
  assign cif.mag[C_PS]  = mag_v1;
  assign cif.pick[C_PS] = pick_q[P_PS];

  // zero sequence and per-phase quantities do not exist on a delta connection
  wire [NCMP-1:0] active = delta ? DELTA_ACTIVE : WYE_ACTIVE;   // see RL13
  wire [NCMP-1:0] elem_d = active & ((UNDER_SLOTS & cif.below) | (~UNDER_SLOTS & cif.above));   // see RL1 see RL2
  wire [2:0] uv_set = delta ? elem_d[C_UVPP +: 3] : elem_d[C_UV1 +: 3];   // see RL3
  wire [2:0] ov_set = delta ? elem_d[C_OVPP +: 3] : elem_d[C_OV1 +: 3];   // see RL5
  wire       uv3_d  = &uv_set;   // see RL4
  wire       ov3_d  = &ov_set;   // see RL6
  wire [3:0] wi_src = delta ? {elem_d[C_NQ], elem_d[C_UVPP +: 3]}        // see RL11
                            : {elem_d[C_ZS], elem_d[C_UV1 +: 3]};        // see RL10
  wire [3:0] wi_d   = wi_en ? wi_src : 4'h0;

  // all element bits move on the same tick so consumers never see a mixed set
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      elem_q              <= '0;
      three_phase_under_q <= 1'b0;
      three_phase_over_q  <= 1'b0;
      weak_infeed_q       <= 4'h0;
    end else if (tick_q) begin   // see RL15
      elem_q              <= elem_d;   // see RL12
      three_phase_under_q <= uv3_d;
      three_phase_over_q  <= ov3_d;
      weak_infeed_q       <= wi_d;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  wire [2:0] ev = {tick_q & (elem_d != elem_q), tick_q & ov3_d & ~three_phase_over_q,
                   tick_q & uv3_d & ~three_phase_under_q};
  wire [2:0] istat_d = (istat_q & ~(wr_istat ? w1c_bits[2:0] : 3'h0)) | ev;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      istat_q <= 3'h0;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q   <= |(istat_d & imask_q);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_tick_wye;
    tick_q && !delta;
  endsequence

  chk_uv1_phase_a: assert property (s_tick_wye |=> elem_q[C_UV1] == ($past(mag_va) < $past(pick_q[P_UV1])))   // see RL3
    else $error("phase a undervoltage bit wrong");
  chk_ov1_phase_b: assert property (s_tick_wye |=> elem_q[C_OV1+1] == ($past(mag_vb) > $past(pick_q[P_OV1])))   // see RL5
    else $error("phase b overvoltage bit wrong");
  chk_three_under: assert property (tick_q |=> three_phase_under_q == &($past(delta) ? elem_q[C_UVPP +: 3] : elem_q[C_UV1 +: 3]))   // see RL4
    else $error("three-phase undervoltage does not match phases");
  chk_three_over: assert property (tick_q |=> three_phase_over_q == &($past(delta) ? elem_q[C_OVPP +: 3] : elem_q[C_OV1 +: 3]))   // see RL6
    else $error("three-phase overvoltage does not match phases");
  chk_weak_gate_off: assert property (tick_q && !wi_en |=> weak_infeed_q == 4'h0 && elem_q == $past(elem_d))   // see RL12
    else $error("weak infeed bits leak or elements lost");
  chk_weak_route_delta: assert property (tick_q && wi_en && delta |=> weak_infeed_q == {elem_q[C_NQ], elem_q[C_UVPP +: 3]})   // see RL11
    else $error("delta weak infeed routing wrong");
  chk_weak_route_wye: assert property (tick_q && wi_en && !delta |=> weak_infeed_q == {elem_q[C_ZS], elem_q[C_UV1 +: 3]})   // see RL10
    else $error("wye weak infeed routing wrong");
  chk_hold_between: assert property (!tick_q |=> $stable(elem_q) && $stable(three_phase_under_q))   // see RL15
    else $error("element bits moved between ticks");
  chk_pick_ceiling: assert property (wr_pick && pick_idx == 6'(P_NQ) |=> pick_q[P_NQ] <= pick_max(P_NQ, $past(delta), $past(r300)))   // see RL8
    else $error("negative sequence pickup above ceiling");
  chk_tick_period: assert property (tick_q |=> !tick_q [*8])
    else $error("processing tick too frequent");

endmodule : vte_top

// file: vte_top_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module vte_top_tb;
  import vte_pkg::*;
  localparam logic [MAG_W-1:0] PK0 [NPICK] = '{16'd10000, 16'd12000, 16'd17000, 16'd15000, 16'd20000,
                                               16'd22000, 16'd3000, 16'd5000, 16'd6000, 16'd20000};
  logic              mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, tpu, tpo, irq;
  logic [MAG_W-1:0]  m [9];
  logic [MAG_W-1:0]  pk [NPICK];
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd;
  logic [1:0]        bresp, rresp;
  logic [NCMP-1:0]   elem, ex, prv;
  logic [3:0]        wi, wi_seen, wie;
  logic [2:0]        uv_seen, imask, ctrl;
  int                fail_count, num_checks, cyc;

  vte_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .mag_va(m[0]), .mag_vb(m[1]), .mag_vc(m[2]),
    .mag_vab(m[3]), .mag_vbc(m[4]), .mag_vca(m[5]), .mag_v0(m[6]), .mag_v2(m[7]), .mag_v1(m[8]),
    .elem_q(elem), .three_phase_under_q(tpu), .three_phase_over_q(tpo), .weak_infeed_q(wi), .irq_q(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  vte_consumer cons_u (.mclk(mclk), .elem_q(elem), .weak_infeed_q(wi), .wi_seen_q(wi_seen), .uv_seen_q(uv_seen));

  // ****
  // models and bus tasks
  // ****
  function automatic logic [NCMP-1:0] calc();
    logic [NCMP-1:0] r;
    int mi;
    int pi;
    for (int s = 0; s < NCMP; s++) begin
      mi = (s < 6) ? s % 3 : (s < 18) ? 3 + s % 3 : (s == 18) ? 6 : (s == 21) ? 8 : 7;
      pi = (s < 18) ? s / 3 : s - 12;
      r[s] = UNDER_SLOTS[s] ? (m[mi] < pk[pi]) : (m[mi] > pk[pi]);
    end
    return r & (ctrl[CTRL_DELTA_BIT] ? DELTA_ACTIVE : WYE_ACTIVE);
  endfunction : calc

  function automatic logic u3(input logic [NCMP-1:0] x);
    return ctrl[CTRL_DELTA_BIT] ? &x[8:6] : &x[2:0];
  endfunction : u3

  function automatic logic o3(input logic [NCMP-1:0] x);
    return ctrl[CTRL_DELTA_BIT] ? &x[14:12] : &x[5:3];
  endfunction : o3

  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask : axw

  task automatic axr(input logic [ADDR_W-1:0] a, input logic [1:0] er);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rready <= 1'b0;
    `CHK("rresp", er, rresp)
  endtask : axr

  task automatic set_ctrl(input logic [2:0] v);
    ctrl = v;
    axw(OFF_CTRL, {29'h0, v}, RESP_OKAY);
  endtask : set_ctrl

  task automatic set_pk(input int k, input logic [MAG_W-1:0] v);
    pk[k] = v;
    axw(OFF_PICK0 + 8'(4 * k), {16'h0, v}, RESP_OKAY);
  endtask : set_pk

  // magnitudes packed as {v1, v2, v0, vca, vbc, vab, vc, vb, va}
  task automatic apply(input string n, input logic [8:0][MAG_W-1:0] v);
    repeat (PROC_INTERVAL_CYC + 3) @(posedge mclk);
    axw(OFF_ISTAT, 32'h0000_0007, RESP_OKAY);
    prv = calc();
    @(posedge mclk);
    for (int i = 0; i < 9; i++) m[i] <= v[i];
    repeat (2 * PROC_INTERVAL_CYC + 3) @(posedge mclk);
    ex  = calc();
    wie = ctrl[CTRL_WI_BIT] ? (ctrl[CTRL_DELTA_BIT] ? {ex[19], ex[8:6]} : {ex[18], ex[2:0]}) : 4'h0;
    `CHK("elem", ex, elem)
    `CHK("three_under", u3(ex), tpu)
    `CHK("three_over", o3(ex), tpo)
    `CHK("weak_infeed", wie, wi_seen)
    `CHK("uv_consumer", ex[2:0], uv_seen)
    axr(OFF_ELEM, RESP_OKAY);
    `CHK("elem_reg", {10'h0, ex}, rd)
    axr(OFF_ISTAT, RESP_OKAY);
    `CHK("istat", {29'h0, |(ex ^ prv), o3(ex) & !o3(prv), u3(ex) & !u3(prv)}, rd)
    `CHK("irq", |(rd[2:0] & imask), irq)
    $display("test %s done", n);
  endtask : apply

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // ****
  // clock, timeout and sequence
  // ****
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[FAIL] timeout exp done got hang");
      close_out();
    end
  end

  initial begin
    {fail_count, num_checks, cyc} = '0;
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    {awaddr, araddr, wdata, imask, ctrl} = '0;
    for (int i = 0; i < 9; i++) m[i] = '0;
    for (int k = 0; k < NPICK; k++) pk[k] = '0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    axr(OFF_CTRL, RESP_OKAY);
    `CHK("ctrl_rst", 32'h0, rd)
    axr(OFF_IMASK, RESP_OKAY);
    `CHK("imask_rst", 32'h0, rd)
    for (int k = 0; k < NPICK; k++) begin
      axr(OFF_PICK0 + 8'(4 * k), RESP_OKAY);
      `CHK("pick_rst", 32'h0, rd)
    end
    axr(8'h80, RESP_DECERR);
    `CHK("unmapped", 32'h0, rd)
    axw(8'h80, 32'h0000_0001, RESP_DECERR);
    axw(OFF_ELEM, 32'hFFFF_FFFF, RESP_OKAY);
    $display("test registers done");
    // pickups kept at or above 2.00 V so bits do not chatter on noise
    // rating first: a pickup is clamped to the ceiling in force when it is written
    set_ctrl(3'h6);
    for (int k = 0; k < NPICK; k++) set_pk(k, PK0[k]);
    imask = 3'h3;
    axw(OFF_IMASK, 32'h0000_0003, RESP_OKAY);
    apply("uv_edge", {16'd100, 16'd5500, 16'd3001, 16'd21000, 16'd16000, 16'd18000, 16'd5000, 16'd10000, 16'd9999});
    apply("uv_three", {16'd100, 16'd5500, 16'd3001, 16'd21000, 16'd16000, 16'd18000, 16'd5000, 16'd9999, 16'd9999});
    imask = 3'h0;
    axw(OFF_IMASK, 32'h0000_0000, RESP_OKAY);
    repeat (3) @(posedge mclk);
    `CHK("irq_masked", 1'b0, irq)
    imask = 3'h3;
    axw(OFF_IMASK, 32'h0000_0003, RESP_OKAY);
    apply("ov_three", {16'd100, 16'd5500, 16'd2999, 16'd21000, 16'd16000, 16'd18000, 16'd12500, 16'd13000, 16'd12001});
    apply("ov_edge", {16'd100, 16'd5500, 16'd2999, 16'd21000, 16'd16000, 16'd18000, 16'd12500, 16'd12000, 16'd12001});
    set_ctrl(3'h4);
    apply("wi_off", {16'd100, 16'd5500, 16'd3001, 16'd21000, 16'd16000, 16'd18000, 16'd5000, 16'd9999, 16'd9999});
    set_ctrl(3'h7);
    apply("delta", {16'd17001, 16'd6001, 16'd100, 16'd20001, 16'd15000, 16'd16999, 16'd100, 16'd100, 16'd100});
    apply("delta_three", {16'd100, 16'd4000, 16'd100, 16'd10000, 16'd15000, 16'd16999, 16'd100, 16'd100, 16'd100});
    // delta-connection pickup ceilings per input rating, values in 10 mV steps
    for (int t = 0; t < 5; t++) begin
      set_ctrl(t < 3 ? 3'h7 : 3'h3);
      set_pk(t == 0 ? P_UVPP : t == 1 ? P_OVPP : t == 2 ? P_NQ : t == 3 ? P_NQ2 : P_PS, 16'hFFFF);
      axr(OFF_PICK0 + 8'(4 * (t == 0 ? P_UVPP : t == 1 ? P_OVPP : t == 2 ? P_NQ : t == 3 ? P_NQ2 : P_PS)), RESP_OKAY);
      `CHK("pick_clamp", t < 2 ? 32'd30000 : t == 2 ? 32'd12000 : t == 3 ? 32'd6000 : 32'd8500, rd)
    end
    $display("test clamp done");
    close_out();
  end
endmodule : vte_top_tb
